// ### pkg/idfc_defs.vh
// Constants for the IEEE and native floating-point word converter.
`ifndef IDFC_DEFS_VH
`define IDFC_DEFS_VH

// ****************************************************************
// Word layout
// ****************************************************************
`define IDFC_WORD_W       32
`define IDFC_EXP_W        8
`define IDFC_FRAC_W       23
`define IDFC_FRAC_HI      22
`define IDFC_NAT_EXP_HI   31
`define IDFC_NAT_EXP_LO   24
`define IDFC_NAT_SIGN     23
`define IDFC_IEEE_SIGN    31
`define IDFC_IEEE_EXP_HI  30
`define IDFC_IEEE_EXP_LO  23

// ****************************************************************
// Exponent codes
// ****************************************************************
`define IDFC_BIAS         8'h7f
`define IDFC_IEEE_EXP_DEN 8'h00
`define IDFC_IEEE_EXP_RES 8'hff
`define IDFC_NAT_EXP_ZERO 8'h80
`define IDFC_NAT_EXP_DEN  8'h81

// ****************************************************************
// Fixed result words
// ****************************************************************
`define IDFC_NAT_ZERO     32'h80000000
`define IDFC_NAT_POS_SAT  32'h7f7fffff
`define IDFC_NAT_NEG_SAT  32'h7f800000
`define IDFC_IEEE_ZERO    32'h00000000
`define IDFC_FRAC_ZERO    23'h000000
`define IDFC_RESET_WORD   32'h00000000

// ****************************************************************
// Modes, directions and timing
// ****************************************************************
`define IDFC_MODE_FAST    1'b0
`define IDFC_MODE_FULL    1'b1
`define IDFC_DIR_TO_NAT   1'b0
`define IDFC_DIR_TO_IEEE  1'b1
`define IDFC_LATENCY      1

`endif

// ### core/idfc_to_ieee.v
// Native-to-IEEE word conversion, purely combinational.
`include "idfc_defs.vh"

module idfc_to_ieee (
    // Native word and mode
    input  wire [31:0] nat_word,
    input  wire        full_mode,
    // IEEE result and its class
    output reg  [31:0] ieee_word,
    output reg         is_zero,
    output reg         is_denorm
);

    // ****************************************************************
    // Field split
    // ****************************************************************
    wire [7:0]  nat_exp  = nat_word[`IDFC_NAT_EXP_HI:`IDFC_NAT_EXP_LO];
    wire        nat_sign = nat_word[`IDFC_NAT_SIGN];
    wire [22:0] nat_frac = nat_word[`IDFC_FRAC_HI:0];

    reg  [7:0]  biased;
    reg  [22:0] mag_frac;

    // ****************************************************************
    // Conversion
    // ****************************************************************
    // A negative native mantissa is 10.f, so its magnitude is 2 - 0.f;
    // an all-zero fraction therefore lifts the exponent by one.
    always @* begin
        biased    = nat_exp + `IDFC_BIAS;
        mag_frac  = nat_frac;
        is_zero   = 1'b0;
        is_denorm = 1'b0;
        if (nat_sign) begin
            if (nat_frac == `IDFC_FRAC_ZERO) begin
                biased = biased + 8'h01;
            end else begin
                mag_frac = `IDFC_FRAC_ZERO - nat_frac;
            end
        end
        if (nat_exp == `IDFC_NAT_EXP_ZERO) begin
            is_zero   = 1'b1;
            ieee_word = `IDFC_IEEE_ZERO;
        end else if (biased == `IDFC_IEEE_EXP_DEN && full_mode) begin
            // Exponent -127 lands on the IEEE denormal code: the hidden
            // one becomes explicit and the fraction drops one place.
            is_denorm = 1'b1;
            ieee_word = {nat_sign, `IDFC_IEEE_EXP_DEN, 1'b1, mag_frac[22:1]};
        end else begin
            ieee_word = {nat_sign, biased, mag_frac};
        end
    end

endmodule // idfc_to_ieee

// ### core/idfc_top.v
// Converter between IEEE single-precision and native floating-point words.
`include "idfc_defs.vh"

module idfc_top (
    // Clock and reset
    input  wire        clock,
    input  wire        nrst,
    // Request side
    input  wire        in_valid,
    input  wire        in_dir,
    input  wire [31:0] in_word,
    input  wire        full_mode,
    output reg         in_ready,
    // Result side
    output reg         out_valid,
    output reg  [31:0] out_word,
    output reg         out_dir,
    // Class of the accepted word
    output reg         out_zero,
    output reg         out_denorm,
    output reg         out_inf,
    output reg         out_nan,
    output reg         out_underflow
);

    // ****************************************************************
    // Functions
    // ****************************************************************

    // Builds a native word from a sign, an unbiased exponent and an
    // IEEE-style magnitude fraction 1.f. The exponent must be no lower
    // than -127; a negative value of exactly one at -127 has no native
    // form and falls to zero.
    function [31:0] pack_native;
        input        neg;
        input [7:0]  exp;
        input [22:0] frac;
        reg   [7:0]  exp_m1;
        begin
            exp_m1 = exp - 8'h01;
            if (!neg) begin
                // Positive: 01.f directly.
                pack_native = {exp, 1'b0, frac};
            end else if (frac == `IDFC_FRAC_ZERO) begin
                // -1.0 * 2^e is 10.0 * 2^(e-1).
                if (exp_m1 == `IDFC_NAT_EXP_ZERO) begin
                    pack_native = `IDFC_NAT_ZERO;
                end else begin
                    pack_native = {exp_m1, 1'b1, `IDFC_FRAC_ZERO};
                end
            end else begin
                // -(1.f) is -2 + (1 - 0.f), so the fraction is negated.
                pack_native = {exp, 1'b1, `IDFC_FRAC_ZERO - frac};
            end
        end
    endfunction

    // True when a word carries the all-zero fraction.
    function frac_is_zero;
        input [31:0] word;
        begin
            frac_is_zero = (word[`IDFC_FRAC_HI:0] == `IDFC_FRAC_ZERO);
        end
    endfunction

    // ****************************************************************
    // IEEE field decode
    // ****************************************************************
    wire        ieee_sign = in_word[`IDFC_IEEE_SIGN];
    wire [7:0]  ieee_exp  = in_word[`IDFC_IEEE_EXP_HI:`IDFC_IEEE_EXP_LO];
    wire [22:0] ieee_frac = in_word[`IDFC_FRAC_HI:0];

    // Input class, used both for the result and for the class outputs.
    wire        exp_low   = (ieee_exp == `IDFC_IEEE_EXP_DEN);
    wire        exp_high  = (ieee_exp == `IDFC_IEEE_EXP_RES);
    wire        cls_zero  = exp_low  &&  frac_is_zero(in_word);
    wire        cls_den   = exp_low  && !frac_is_zero(in_word);
    wire        cls_inf   = exp_high &&  frac_is_zero(in_word);
    wire        cls_nan   = exp_high && !frac_is_zero(in_word);

    // ****************************************************************
    // Native field decode
    // ****************************************************************
    wire [7:0]  nat_exp   = in_word[`IDFC_NAT_EXP_HI:`IDFC_NAT_EXP_LO];
    wire        nat_zero  = (nat_exp == `IDFC_NAT_EXP_ZERO);

    // ****************************************************************
    // Reverse direction
    // ****************************************************************
    wire [31:0] rev_word;
    wire        rev_zero;
    wire        rev_denorm;

    // The native-to-IEEE path lives in its own module so the forward
    // path here stays readable.
    idfc_to_ieee u_to_ieee (
        .nat_word  (in_word),
        .full_mode (full_mode),
        .ieee_word (rev_word),
        .is_zero   (rev_zero),
        .is_denorm (rev_denorm)
    );

    // ****************************************************************
    // Forward direction
    // ****************************************************************
    reg  [31:0] fwd_word;
    reg         fwd_under;
    reg  [7:0]  unbiased;

    // Complete mode checks the special classes first; fast mode only
    // separates zero and denormals from the normal path, which is cheaper but lets
    // infinity and NaN wrap through the exponent arithmetic.
    always @* begin
        unbiased  = ieee_exp - `IDFC_BIAS;
        fwd_under = 1'b0;
        if (full_mode == `IDFC_MODE_FULL) begin
            if (cls_nan) begin
                fwd_word = in_word;
            end else if (cls_inf) begin
                // Top exponent with the extreme fraction for each sign.
                if (ieee_sign) begin
                    fwd_word = `IDFC_NAT_NEG_SAT;
                end else begin
                    fwd_word = `IDFC_NAT_POS_SAT;
                end
            end else if (cls_zero) begin
                fwd_word = `IDFC_NAT_ZERO;
            end else if (cls_den) begin
                if (ieee_frac[`IDFC_FRAC_HI]) begin
                    // 0.1f * 2^-126 is 1.f * 2^-127.
                    fwd_word = pack_native(ieee_sign, `IDFC_NAT_EXP_DEN,
                                           {ieee_frac[21:0], 1'b0});
                end else begin
                    fwd_word  = `IDFC_NAT_ZERO;
                    fwd_under = 1'b1;
                end
            end else begin
                fwd_word = pack_native(ieee_sign, unbiased, ieee_frac);
            end
        end else begin
            // Denormals also go to zero here; any value is allowed.
            if (exp_low) begin
                fwd_word = `IDFC_NAT_ZERO;
            end else begin
                fwd_word = pack_native(ieee_sign, unbiased, ieee_frac);
            end
        end
    end

    // ****************************************************************
    // Next-state selection
    // ****************************************************************
    reg  [31:0] next_word;
    reg         next_zero;
    reg         next_denorm;
    reg         next_inf;
    reg         next_nan;
    reg         next_under;

    // Class outputs describe the accepted word in the format it came in, except reverse next_denorm: a denormal IEEE result in complete mode.
    always @* begin
        if (in_dir == `IDFC_DIR_TO_IEEE) begin
            next_word   = rev_word;
            next_zero   = nat_zero;
            next_denorm = rev_denorm;
            next_inf    = 1'b0;
            next_nan    = 1'b0;
            next_under  = 1'b0;
        end else begin
            next_word   = fwd_word;
            next_zero   = cls_zero;
            next_denorm = cls_den;
            next_inf    = cls_inf;
            next_nan    = cls_nan;
            next_under  = fwd_under;
        end
    end

    // ****************************************************************
    // Result register
    // ****************************************************************
    // Every request after the first edge out of reset is taken, so the result lands one edge after the
    // request and holds until the next one; valid is a single pulse.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            in_ready      <= 1'b0;
            out_valid     <= 1'b0;
            out_word      <= `IDFC_RESET_WORD;
            out_dir       <= `IDFC_DIR_TO_NAT;
            out_zero      <= 1'b0;
            out_denorm    <= 1'b0;
            out_inf       <= 1'b0;
            out_nan       <= 1'b0;
            out_underflow <= 1'b0;
        end else begin
            in_ready  <= 1'b1;
            out_valid <= in_valid && in_ready;
            if (in_valid && in_ready) begin
                out_word      <= next_word;
                out_dir       <= in_dir;
                out_zero      <= next_zero;
                out_denorm    <= next_denorm;
                out_inf       <= next_inf;
                out_nan       <= next_nan;
                out_underflow <= next_under;
            end
        end
    end

    // Reverse-path zero flag is folded into next_zero via nat_zero; the
    // submodule's copy is kept for its own bench and left unread here.
    wire unused_rev_zero = rev_zero;

endmodule // idfc_top

// ### sim/idfc_props.sv
// Port-level checks for the IEEE and native word converter.
`include "idfc_defs.vh"

module idfc_props (
    // Clock and reset
    input wire logic        clock,
    input wire logic        nrst,
    // Request side
    input wire logic        in_valid,
    input wire logic        in_dir,
    input wire logic [31:0] in_word,
    input wire logic        full_mode,
    input wire logic        in_ready,
    // Result side
    input wire logic        out_valid,
    input wire logic [31:0] out_word,
    input wire logic        out_dir,
    input wire logic        out_zero,
    input wire logic        out_denorm,
    input wire logic        out_inf,
    input wire logic        out_nan,
    input wire logic        out_underflow
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    // Accepted words by direction, with the IEEE exponent split out.
    wire logic       take = in_valid && in_ready;
    wire logic       fwd  = take && !in_dir;
    wire logic [7:0] ex   = in_word[30:23];
    wire logic       fz   = in_word[22:0] == 23'h0;
    sequence s_nan; fwd && full_mode && ex == 8'hff && !fz; endsequence
    sequence s_inf; fwd && full_mode && ex == 8'hff && fz; endsequence
    sequence s_zero; fwd && ex == 8'h00 && fz; endsequence
    sequence s_under; fwd && full_mode && ex == 8'h00 && !fz && !in_word[22]; endsequence
    sequence s_pos; fwd && !in_word[31] && ex != 8'h00 && ex != 8'hff; endsequence

    chk_valid_lat: assert property (take |=> out_valid && out_dir == $past(in_dir))
        else $error("Result strobe or direction missing.");
    chk_no_spurious: assert property (!take |=> !out_valid)
        else $error("Result strobe without an accepted word.");
    chk_word_hold: assert property (!take |=> $stable(out_word))
        else $error("Result word moved without a request.");
    chk_nan_pass: assert property (s_nan |=> out_word == $past(in_word) && out_nan)
        else $error("Not-a-number word was altered.");
    chk_inf_sat: assert property (s_inf |=> out_inf && out_word ==
        ($past(in_word[31]) ? `IDFC_NAT_NEG_SAT : `IDFC_NAT_POS_SAT))
        else $error("Infinity did not saturate.");
    chk_zero_fwd: assert property (s_zero |=> out_word == `IDFC_NAT_ZERO && out_zero)
        else $error("Zero not mapped to native zero.");
    chk_under_zero: assert property (s_under |=> out_word == `IDFC_NAT_ZERO && out_underflow)
        else $error("Small denormal did not underflow.");
    chk_pos_normal: assert property (s_pos |=>
        out_word == {$past(ex) - 8'h7f, 1'b0, $past(in_word[22:0])})
        else $error("Positive normal converted wrongly.");
    chk_rev_zero: assert property (take && in_dir && in_word[31:24] == 8'h80 |=>
        out_word == `IDFC_IEEE_ZERO && out_zero)
        else $error("Native zero not mapped to IEEE zero.");
endmodule // idfc_props

bind idfc_top idfc_props u_props (
    .clock(clock), .nrst(nrst), .in_valid(in_valid), .in_dir(in_dir), .in_word(in_word),
    .full_mode(full_mode), .in_ready(in_ready), .out_valid(out_valid), .out_word(out_word),
    .out_dir(out_dir), .out_zero(out_zero), .out_denorm(out_denorm), .out_inf(out_inf),
    .out_nan(out_nan), .out_underflow(out_underflow)
);

// ### sim/idfc_src.sv
// Processor-side model that issues words to the converter and consumes results.
module idfc_src (
    // Clock and returned strobe
    input  wire logic   clock,
    input  wire logic   out_valid,
    // Request towards the converter
    output logic        in_valid,
    output logic        in_dir,
    output logic        full_mode,
    output logic [31:0] in_word
);
    timeunit 1ns;
    timeprecision 1ps;
    int got_cnt = 0;

    // Results are taken on the edge that shows the strobe.
    always @(posedge clock) if (out_valid === 1'b1) got_cnt <= got_cnt + 1;

    // Present one word; holding valid across calls gives back-to-back requests.
    task put(input logic d, input logic m, input logic [31:0] w);
        @(posedge clock);
        in_valid  <= 1'b1;
        in_dir    <= d;
        full_mode <= m;
        in_word   <= w;
    endtask

    // Withdraw; the word is inverted so a stale value never looks current.
    task idle();
        @(posedge clock);
        in_valid <= 1'b0;
        in_word  <= ~in_word;
    endtask

    initial begin
        in_valid  = 1'b0;
        in_dir    = 1'b0;
        full_mode = 1'b0;
        in_word   = 32'h0;
    end
endmodule // idfc_src

// ### sim/tb_idfc_top.sv
// Self-checking testbench for the IEEE and native word converter.
module tb_idfc_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic             clock = 1'b0;
    logic             nrst  = 1'b0;
    wire logic        in_valid, in_dir, full_mode, in_ready, out_valid, out_dir;
    wire logic [31:0] in_word, out_word;
    wire logic [4:0]  flags;
    int               fails = 0;
    int               cmp_count = 0;

    idfc_top dut (
        .clock(clock), .nrst(nrst), .in_valid(in_valid), .in_dir(in_dir), .in_word(in_word),
        .full_mode(full_mode), .in_ready(in_ready), .out_valid(out_valid), .out_word(out_word),
        .out_dir(out_dir), .out_zero(flags[4]), .out_denorm(flags[3]), .out_inf(flags[2]),
        .out_nan(flags[1]), .out_underflow(flags[0])
    );
    idfc_src src (.clock(clock), .out_valid(out_valid), .in_valid(in_valid), .in_dir(in_dir),
        .full_mode(full_mode), .in_word(in_word));

    // 20 MHz clock.
    always #25 clock = ~clock;

    // ****************************************************************
    // Shared checks
    // ****************************************************************
    task same(input logic [33:0] got, input logic [33:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // The answer stands just after the edge that follows acceptance.
    task check(input logic d, input logic [31:0] e, input logic [4:0] f);
        same({out_valid, out_dir, flags}, {1'b1, d, f});
        same(out_word, e);
    endtask
    task conv(input logic d, m, input logic [31:0] w, e, input logic [4:0] f);
        src.put(d, m, w);
        src.idle();
        #1 check(d, e, f);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task test_fast();
        conv(1'b0, 1'b0, 32'h3f800000, 32'h00000000, 5'h00);
        conv(1'b0, 1'b0, 32'hbf800000, 32'hff800000, 5'h00);
        conv(1'b0, 1'b0, 32'h40000000, 32'h01000000, 5'h00);
        conv(1'b0, 1'b0, 32'h3fc00000, 32'h00400000, 5'h00);
        conv(1'b0, 1'b0, 32'hbfc00000, 32'h00c00000, 5'h00);
        conv(1'b0, 1'b0, 32'h80000000, 32'h80000000, 5'h10);
        $display("test_fast done");
    endtask
    task test_full();
        conv(1'b0, 1'b1, 32'h7fc00001, 32'h7fc00001, 5'h02);
        conv(1'b0, 1'b1, 32'h7f800000, 32'h7f7fffff, 5'h04);
        conv(1'b0, 1'b1, 32'hff800000, 32'h7f800000, 5'h04);
        conv(1'b0, 1'b1, 32'h00600000, 32'h81400000, 5'h08);
        conv(1'b0, 1'b1, 32'h80600000, 32'h81c00000, 5'h08);
        conv(1'b0, 1'b1, 32'h00000001, 32'h80000000, 5'h09);
        conv(1'b0, 1'b1, 32'h00000000, 32'h80000000, 5'h10);
        $display("test_full done");
    endtask
    task test_reverse();
        conv(1'b1, 1'b0, 32'h00000000, 32'h3f800000, 5'h00);
        conv(1'b1, 1'b0, 32'hff800000, 32'hbf800000, 5'h00);
        conv(1'b1, 1'b0, 32'h80000000, 32'h00000000, 5'h10);
        conv(1'b1, 1'b1, 32'h81000000, 32'h00400000, 5'h08);
        $display("test_reverse done");
    endtask
    // Two words on consecutive edges, then the result must hold.
    task test_b2b();
        int n;
        // The previous scenario's strobe is still counted on the next edge.
        @(posedge clock);
        #1 n = src.got_cnt;
        src.put(1'b0, 1'b0, 32'h40000000);
        src.put(1'b1, 1'b0, 32'hff800000);
        #1 check(1'b0, 32'h01000000, 5'h00);
        src.idle();
        #1 check(1'b1, 32'hbf800000, 5'h00);
        @(posedge clock);
        #1 same({out_valid, out_word}, 33'h0bf800000);
        same(34'(src.got_cnt - n), 34'd2);
        $display("test_b2b done");
    endtask
    // A word offered on the release edge meets in_ready low and is dropped.
    task test_refuse();
        @(posedge clock);
        nrst <= 1'b0;
        #1 same({in_ready, out_valid, out_word}, 34'h0);
        src.put(1'b0, 1'b0, 32'h40000000);
        nrst <= 1'b1;
        src.idle();
        #1 same(in_ready, 1'b1);
        @(posedge clock);
        #1 same({out_valid, out_word}, 33'h0);
        $display("test_refuse done");
    endtask

    task complete_run();
        $display("compares %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Main sequence: reset for five cycles, then every scenario.
    initial begin
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        repeat (2) @(posedge clock);
        test_fast();
        test_full();
        test_reverse();
        test_b2b();
        test_refuse();
        complete_run();
    end

    // The tests need about 50 cycles; 2000 cycles means a hang.
    initial begin
        #100000;
        fails++;
        $display("ERROR at %0t: watchdog expired", $time);
        complete_run();
    end
endmodule // tb_idfc_top
